// ### hdl/io_loopback_test_logic.sv
// Acceptance-test logic: IO mux, clock counters, FIFO loopback, TTL port
// Assumes external FIFOs run on clk; IO, TTL and PLL inputs are asynchronous
//
// Operation
// - Lower 24 lines choose PLL clock or data
// - Clock driven only when output and selected
// - Each PLL clock feeds a 32-bit counter
// - Counters stop when reference count bit 24 sets
// - Control register selects count for readback
// - Data lines driven from output data registers
// - IO reads return sampled pins
// - Per channel TX to RX copy engine
// - Host may read and write FIFOs directly
// - FIFO flags readable and pace the engines
// - Twelve open-drain TTL outputs, zero pulls low
// - TTL read returns buffered line state
// - Answer only addresses 0x2000 to 0x3fff
// - Control registers read/write, ports one-way
// - Design identification value readable by host
// - Count control 0x2048, count data 0x204c
// - FIFO flag port at 0x2044
// - IO data ports at 0x2018, 0x201c
`timescale 1ns/10ps
`default_nettype none
`include "io_loop_cfg.svh"
module io_loopback_test_logic (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [15:0]             lb_addr,
  input  wire logic                    lb_wr,
  input  wire logic                    lb_rd,
  input  wire io_loop_pkg::word_t      lb_wdata,
  output logic                         lb_ack,
  output io_loop_pkg::word_t           lb_rdata,
  input  wire logic [`N_PLL-1:0]       pll_clk,
  input  wire logic [2*`N_IO_HALF-1:0] io_in,
  output logic [2*`N_IO_HALF-1:0]      io_out,
  output logic [2*`N_IO_HALF-1:0]      io_oe_n,
  input  wire logic [`N_TTL-1:0]       ttl_in,
  output logic [`N_TTL-1:0]            ttl_out,
  output logic [`N_TTL-1:0]            ttl_oe_n,
  input  wire logic [`N_CH-1:0]        tx_empty,
  input  wire logic [`N_CH-1:0]        rx_full,
  input  wire io_loop_pkg::word_t      tx_rdata [`N_CH],
  output logic [`N_CH-1:0]             tx_rd,
  output logic [`N_CH-1:0]             rx_wr,
  output io_loop_pkg::word_t           rx_wdata [`N_CH]
);
  import io_loop_pkg::*;

  // True when a strobe hits the given register address
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a[15:2] == off[15:2]);
  endfunction

  logic [`N_CH-1:0]        rxtx_en;
  logic [2*`N_IO_HALF-1:0] dir;
  logic [2*`N_IO_HALF-1:0] io_data;
  logic [`N_TTL-1:0]       ttl_data;
  word_t                   osc_ctl;
  logic [2*`N_IO_HALF-1:0] io_s1, io_s2;
  logic [`N_TTL-1:0]       ttl_s1, ttl_s2;
  logic [`N_PLL-1:0]       pll_s1, pll_s2, pll_s3;
  word_t                   cnt [`N_CNT];
  logic                    in_region;
  logic                    fifo_hit;
  logic [2:0]              fifo_ch;
  logic                    fifo_wait;
  logic [2:0]              wait_ch;
  logic [`N_CH-1:0]        done_vec;
  word_t                   host_rd_word [`N_CH];
  logic [4:0]              cnt_sel;
  logic [2*`N_IO_HALF-1:0] line_clk;
  logic [2*`N_IO_HALF-1:0] line_sel;

  assign in_region = lb_addr[`REGION_BIT] && lb_addr >= `REGION_LO
                     && lb_addr <= `REGION_HI;
  assign fifo_hit  = in_region && lb_addr[15:5] == `ADDR_FIFO0 >> 5;
  assign fifo_ch   = lb_addr[4:2];
  assign cnt_sel   = osc_ctl[`OSC_SEL_MSB:`OSC_SEL_LSB];
  // Clock source and select spread over all lines, upper lines never pick a clock
  assign line_clk  = {{(2*`N_IO_HALF-`N_PLL){1'b0}}, pll_s2};
  assign line_sel  = {{(2*`N_IO_HALF-`N_PLL){1'b0}}, osc_ctl[`N_PLL-1:0]};

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for pins
  always_ff @(posedge clk) begin
    if (rst) begin
      io_s1  <= '0;
      io_s2  <= '0;
      ttl_s1 <= '0;
      ttl_s2 <= '0;
      pll_s1 <= '0;
      pll_s2 <= '0;
      pll_s3 <= '0;
    end else begin
      io_s1  <= io_in;
      io_s2  <= io_s1;
      ttl_s1 <= ttl_in;
      ttl_s2 <= ttl_s1;
      pll_s1 <= pll_clk;
      pll_s2 <= pll_s1;
      pll_s3 <= pll_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rxtx_en  <= '0;
      dir      <= '0;
      io_data  <= '0;
      ttl_data <= '1;
      osc_ctl  <= '0;
    end else if (lb_wr && in_region) begin
      if (hit(lb_addr, `ADDR_RXTX))    rxtx_en <= lb_wdata[`N_CH-1:0];
      if (hit(lb_addr, `ADDR_DIR_LO))  dir[`N_IO_HALF-1:0] <= lb_wdata[`N_IO_HALF-1:0];
      if (hit(lb_addr, `ADDR_DIR_HI))  dir[2*`N_IO_HALF-1:`N_IO_HALF] <= lb_wdata[`N_IO_HALF-1:0];
      if (hit(lb_addr, `ADDR_IO_LO))   io_data[`N_IO_HALF-1:0] <= lb_wdata[`N_IO_HALF-1:0];
      if (hit(lb_addr, `ADDR_IO_HI))   io_data[2*`N_IO_HALF-1:`N_IO_HALF] <=
                                         lb_wdata[`N_IO_HALF-1:0];
      if (hit(lb_addr, `ADDR_TTL))     ttl_data <= lb_wdata[`N_TTL-1:0];
      if (hit(lb_addr, `ADDR_OSC_CNT)) osc_ctl <= lb_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frequency counters, index 24 counts clk as reference
  always_ff @(posedge clk) begin
    if (rst || osc_ctl[`OSC_CLR_BIT]) begin
      for (int i = 0; i < `N_CNT; i++) cnt[i] <= '0;
    end else if (osc_ctl[`OSC_RUN_BIT] && !cnt[`N_PLL][`REF_STOP_BIT]) begin
      for (int i = 0; i < `N_PLL; i++) begin
        if (pll_s2[i] && !pll_s3[i]) cnt[i] <= cnt[i] + 32'h1;
      end
      cnt[`N_PLL] <= cnt[`N_PLL] + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // IO and TTL pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      io_out   <= '0;
      io_oe_n  <= '1;
      ttl_out  <= '0;
      ttl_oe_n <= '1;
    end else begin
      io_oe_n  <= ~dir;
      io_out   <= (line_sel & line_clk)
                  | (~line_sel & io_data);
      ttl_out  <= '0;
      ttl_oe_n <= ttl_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Loopback channels
  chan_if chn [`N_CH] ();
  for (genvar c = 0; c < `N_CH; c++) begin : g_ch
    assign chn[c].en         = rxtx_en[c];
    assign chn[c].tx_empty   = tx_empty[c];
    assign chn[c].rx_full    = rx_full[c];
    assign chn[c].tx_rdata   = tx_rdata[c];
    assign chn[c].host_rd    = lb_rd && fifo_hit && fifo_ch == c;
    assign chn[c].host_wr    = lb_wr && fifo_hit && fifo_ch == c;
    assign chn[c].host_wdata = lb_wdata;
    assign tx_rd[c]          = chn[c].tx_rd;
    assign rx_wr[c]          = chn[c].rx_wr;
    assign rx_wdata[c]       = chn[c].rx_wdata;
    assign done_vec[c]       = chn[c].host_done;
    assign host_rd_word[c]   = chn[c].host_rdata;
    loopback_channel u_chan (
      .clk (clk),
      .rst (rst),
      .ch  (chn[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Read answers; FIFO reads answer once the engine has the word
  always_ff @(posedge clk) begin
    if (rst) begin
      lb_ack    <= 1'b0;
      lb_rdata  <= '0;
      fifo_wait <= 1'b0;
      wait_ch   <= '0;
    end else begin
      lb_ack <= 1'b0;
      if (fifo_wait && done_vec[wait_ch]) begin
        lb_ack    <= 1'b1;
        lb_rdata  <= host_rd_word[wait_ch];
        fifo_wait <= 1'b0;
      end else if (lb_rd && fifo_hit) begin
        fifo_wait <= 1'b1;
        wait_ch   <= fifo_ch;
      end else if (lb_wr && in_region) begin
        lb_ack <= 1'b1;
      end else if (lb_rd && in_region) begin
        lb_ack   <= 1'b1;
        lb_rdata <= '0;
        if (hit(lb_addr, `ADDR_BASE))      lb_rdata <= `DESIGN_ID;
        if (hit(lb_addr, `ADDR_RXTX))      lb_rdata[`N_CH-1:0] <= rxtx_en;
        if (hit(lb_addr, `ADDR_DIR_LO))    lb_rdata[`N_IO_HALF-1:0] <= dir[`N_IO_HALF-1:0];
        if (hit(lb_addr, `ADDR_DIR_HI))    lb_rdata[`N_IO_HALF-1:0] <=
                                             dir[2*`N_IO_HALF-1:`N_IO_HALF];
        if (hit(lb_addr, `ADDR_IO_LO))     lb_rdata[`N_IO_HALF-1:0] <=
                                             io_s2[`N_IO_HALF-1:0];
        if (hit(lb_addr, `ADDR_IO_HI))     lb_rdata[`N_IO_HALF-1:0] <=
                                             io_s2[2*`N_IO_HALF-1:`N_IO_HALF];
        if (hit(lb_addr, `ADDR_TTL))       lb_rdata[`N_TTL-1:0] <= ttl_s2;
        if (hit(lb_addr, `ADDR_FIFO_FLAG)) lb_rdata[2*`N_CH-1:0] <=
                                             {rx_full, tx_empty};
        if (hit(lb_addr, `ADDR_OSC_CNT))   lb_rdata <= osc_ctl;
        if (hit(lb_addr, `ADDR_OSC_DATA))  lb_rdata <= (cnt_sel >= `REF_CNT_IDX) ?
                                             cnt[`N_PLL] : cnt[cnt_sel];
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/loopback_channel.sv
// One channel: TX FIFO to RX FIFO copy engine plus direct host access
// Assumes FIFO read data valid the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module loopback_channel (
  input  wire logic clk,
  input  wire logic rst,
  chan_if.chan      ch
);
  import io_loop_pkg::*;

  chan_state_t state;
  logic        pend_rd;
  logic        pend_wr;
  word_t       pend_data;

  ////////////////////////////////////////////////////////////////////////
  // Host requests held until the engine is idle
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_rd   <= 1'b0;
      pend_wr   <= 1'b0;
      pend_data <= '0;
    end else begin
      if (ch.host_rd) begin
        pend_rd <= 1'b1;
      end else if (state == st_idle && pend_rd) begin
        pend_rd <= 1'b0;
      end
      if (ch.host_wr) begin
        pend_wr   <= 1'b1;
        pend_data <= ch.host_wdata;
      end else if (state == st_idle && pend_wr && !pend_rd) begin
        pend_wr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Engine: host access first, then flag-paced copy
  always_ff @(posedge clk) begin
    if (rst) begin
      state         <= st_idle;
      ch.tx_rd      <= 1'b0;
      ch.rx_wr      <= 1'b0;
      ch.rx_wdata   <= '0;
      ch.host_rdata <= '0;
      ch.host_done  <= 1'b0;
    end else begin
      ch.tx_rd     <= 1'b0;
      ch.rx_wr     <= 1'b0;
      ch.host_done <= 1'b0;
      case (state)
        st_idle: begin
          if (pend_rd) begin
            ch.tx_rd <= 1'b1;
            state    <= st_hrd;
          end else if (pend_wr) begin
            ch.rx_wr     <= 1'b1;
            ch.rx_wdata  <= pend_data;
            ch.host_done <= 1'b1;
          end else if (ch.en && !ch.tx_empty && !ch.rx_full) begin
            ch.tx_rd <= 1'b1;
            state    <= st_rd;
          end
        end
        st_rd:   state <= st_cap;
        st_cap: begin
          ch.rx_wdata <= ch.tx_rdata;
          ch.rx_wr    <= 1'b1;
          state       <= st_wr;
        end
        st_wr:   state <= st_idle;                        // Flags settle before next look
        st_hrd:  state <= st_hcap;
        st_hcap: begin
          ch.host_rdata <= ch.tx_rdata;
          ch.host_done  <= 1'b1;
          state         <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### inc/chan_if.sv
// Per-channel link between the register logic and a loopback engine
// Assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface chan_if;
  import io_loop_pkg::*;
  logic  en;
  logic  tx_empty;
  logic  rx_full;
  word_t tx_rdata;
  logic  host_rd;
  logic  host_wr;
  word_t host_wdata;
  logic  tx_rd;
  logic  rx_wr;
  word_t rx_wdata;
  word_t host_rdata;
  logic  host_done;
  modport ctrl (output en, tx_empty, rx_full, tx_rdata, host_rd, host_wr, host_wdata,
                input tx_rd, rx_wr, rx_wdata, host_rdata, host_done);
  modport chan (input en, tx_empty, rx_full, tx_rdata, host_rd, host_wr, host_wdata,
                output tx_rd, rx_wr, rx_wdata, host_rdata, host_done);
endinterface
`default_nettype wire

// ### inc/io_loop_cfg.svh
// Constants for the loopback acceptance-test logic
// Assumes byte addresses on the local bus, one 32-bit word per register
`ifndef IO_LOOP_CFG_SVH
`define IO_LOOP_CFG_SVH

// Local address window owned by this logic
`define REGION_BIT      13
`define REGION_LO       16'h2000
`define REGION_HI       16'h3fff

// Register byte addresses
`define ADDR_BASE       16'h2000
`define ADDR_RXTX       16'h2004
`define ADDR_DIR_LO     16'h2008
`define ADDR_DIR_HI     16'h200c
`define ADDR_IO_LO      16'h2018
`define ADDR_IO_HI      16'h201c
`define ADDR_FIFO0      16'h2020
`define ADDR_TTL        16'h2040
`define ADDR_FIFO_FLAG  16'h2044
`define ADDR_OSC_CNT    16'h2048
`define ADDR_OSC_DATA   16'h204c

// Sizes
`define N_CH            8
`define N_PLL           24
`define N_IO_HALF       20
`define N_TTL           12
`define N_CNT           25

// Clock/count control fields
`define OSC_SEL_LSB     24
`define OSC_SEL_MSB     28
`define OSC_RUN_BIT     29
`define OSC_CLR_BIT     30
`define REF_STOP_BIT    24
`define REF_CNT_IDX     5'h18

// Design identification, value is arbitrary
`define DESIGN_ID       32'h5a5a_0001

`endif

// ### inc/io_loop_pkg.sv
// Types shared by the loopback logic
// Assumes io_loop_cfg.svh is on the include path
package io_loop_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {st_idle, st_rd, st_cap, st_wr, st_hrd, st_hcap} chan_state_t;
endpackage

// ### testbench/fifo_model.sv
// External TX and RX FIFOs of all channels
// Assumes the bench loads, flags and inspects it by hierarchy
`timescale 1ns/10ps
`default_nettype none
module fifo_model (
  input wire logic               clk,
  input wire logic [7:0]         tx_rd,
  input wire logic [7:0]         rx_wr,
  input wire io_loop_pkg::word_t rx_wdata [8],
  output logic [7:0]             tx_empty,
  output logic [7:0]             rx_full,
  output io_loop_pkg::word_t     tx_rdata [8]
);
  import io_loop_pkg::*;
  word_t      txq [8][$];
  word_t      rxq [8][$];
  logic [7:0] held;
  // Empty FIFOs, nothing full
  initial begin
    tx_empty = 8'hff;
    rx_full = 8'h00;
    held = 8'h00;
    for (int i = 0; i < 8; i++) tx_rdata[i] = 32'h0;
  end
  // Bench fills a TX FIFO
  task automatic load(input int ch, input word_t w);
    txq[ch].push_back(w);
    tx_empty[ch] = 1'b0;
  endtask
  // Word valid one cycle after the strobe, inverted after
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (tx_rd[i] && txq[i].size() > 0) begin
        tx_empty[i] <= (txq[i].size() == 1);
        tx_rdata[i] <= txq[i].pop_front();
      end else if (held[i]) begin
        tx_rdata[i] <= ~tx_rdata[i];
      end
      held[i] <= tx_rd[i];
      if (rx_wr[i]) rxq[i].push_back(rx_wdata[i]);
    end
  end
endmodule
`default_nettype wire

// ### testbench/io_loop_properties.sv
// Checker on the ports of the loopback test logic
// Assumes bound to the top module, single clock domain
`timescale 1ns/10ps
`default_nettype none
`include "io_loop_cfg.svh"
module io_loop_properties (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [15:0]        lb_addr,
  input wire logic               lb_wr,
  input wire logic               lb_rd,
  input wire logic               lb_ack,
  input wire io_loop_pkg::word_t lb_rdata,
  input wire logic [39:0]        io_oe_n,
  input wire logic [11:0]        ttl_out,
  input wire logic [7:0]         tx_empty,
  input wire logic [7:0]         rx_full,
  input wire io_loop_pkg::word_t tx_rdata [8],
  input wire logic [7:0]         tx_rd,
  input wire logic [7:0]         rx_wr,
  input wire io_loop_pkg::word_t rx_wdata [8]
);
  import io_loop_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Engine copy on channel 0 and host read of FIFO 0
  sequence s_copy; tx_rd[0] ##2 rx_wr[0]; endsequence
  sequence s_fifo_rd; lb_rd && lb_addr == `ADDR_FIFO0; endsequence
  ////////////////////////////////////////
  AST_ACK_PULSE: assert property (lb_ack |=> !lb_ack)
    else $error("ack held too long");
  AST_OUTSIDE: assert property (
    (lb_rd || lb_wr) && lb_addr[15:13] != 3'b001 |=> (!lb_ack) [*3])
    else $error("ack outside region");
  AST_ID: assert property (
    lb_rd && lb_addr == `ADDR_BASE |=> lb_ack && lb_rdata == `DESIGN_ID)
    else $error("bad id read");
  AST_FLAG: assert property (lb_rd && lb_addr == `ADDR_FIFO_FLAG
    |=> lb_ack && lb_rdata == {16'h0, $past(rx_full), $past(tx_empty)})
    else $error("bad flag read");
  AST_FIFO_ACK: assert property (s_fifo_rd |=> (!lb_ack) [*3] ##[1:6] lb_ack)
    else $error("fifo read ack timing");
  AST_TTL_OD: assert property (ttl_out == 12'h000)
    else $error("ttl drives high");
  AST_STB: assert property (|tx_rd |=> (tx_rd & $past(tx_rd)) == 8'h00)
    else $error("read strobe too long");
  AST_PACE: assert property ((tx_rd & $past(tx_empty)) == 8'h00)
    else $error("read of empty fifo");
  AST_COPY: assert property (s_copy |-> rx_wdata[0] == $past(tx_rdata[0]))
    else $error("copied word differs");
  AST_RESET: assert property (disable iff (1'b0)
    rst |=> io_oe_n == '1 && tx_rd == 8'h00 && !lb_ack)
    else $error("outputs not reset");
endmodule
`default_nettype wire

// ### testbench/io_loopback_test_logic_tb_top.sv
// Self-checking bench for the loopback test logic
// Assumes the design, checker and FIFO model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "io_loop_cfg.svh"
module io_loopback_test_logic_tb_top;
  import io_loop_pkg::*;
  logic        clk, rst, lb_wr, lb_rd, lb_ack, got;
  logic [15:0] lb_addr;
  word_t       lb_wdata, lb_rdata, q, r;
  logic [23:0] pll_clk;
  logic [39:0] io_in, io_out, io_oe_n, ext;
  logic [11:0] ttl_in, ttl_out, ttl_oe_n, ttl_low;
  logic [7:0]  tx_empty, rx_full, tx_rd, rx_wr, pcnt;
  word_t       tx_rdata [8];
  word_t       rx_wdata [8];
  word_t       bridge_cfg [4];
  int          err_total, samples_checked, cyc;
  // Pins: pull-up on TTL, far end drives ext on input lines
  assign pll_clk = {{22{pcnt[2]}}, pcnt[3], pcnt[2]};
  assign io_in = (io_out & ~io_oe_n) | (ext & io_oe_n);
  assign ttl_in = (ttl_out | ttl_oe_n) & ~ttl_low;
  io_loopback_test_logic dut_u (.clk(clk), .rst(rst), .lb_addr(lb_addr), .lb_wr(lb_wr),
    .lb_rd(lb_rd), .lb_wdata(lb_wdata), .lb_ack(lb_ack), .lb_rdata(lb_rdata),
    .pll_clk(pll_clk), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .ttl_in(ttl_in),
    .ttl_out(ttl_out), .ttl_oe_n(ttl_oe_n), .tx_empty(tx_empty), .rx_full(rx_full),
    .tx_rdata(tx_rdata), .tx_rd(tx_rd), .rx_wr(rx_wr), .rx_wdata(rx_wdata));
  fifo_model fm_u (.clk(clk), .tx_rd(tx_rd), .rx_wr(rx_wr), .rx_wdata(rx_wdata),
    .tx_empty(tx_empty), .rx_full(rx_full), .tx_rdata(tx_rdata));
  ////////////////////////////////////////
  // Clock, PLL stimulus and hang limit
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    #1 pcnt <= pcnt + 8'h1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input word_t e, input word_t g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input word_t lo, input word_t hi, input word_t g);
    chk(n, 32'h1, {31'h0, (g >= lo && g <= hi) === 1'b1});
  endtask
  // One-cycle request, bounded wait for ack
  task automatic bus(input logic w, input logic [15:0] a, input word_t d);
    @(posedge clk) #1;
    lb_addr = a;
    lb_wdata = d;
    lb_wr = w && bridge_cfg[0][0];
    lb_rd = !w && bridge_cfg[0][0];
    @(posedge clk) #1;
    lb_wr = 1'b0;
    lb_rd = 1'b0;
    got = 1'b0;
    for (int i = 0; i < 12 && !got; i++) begin
      if (lb_ack === 1'b1) begin
        got = 1'b1;
        q = lb_rdata;
      end else @(posedge clk) #1;
    end
  endtask
  task automatic rdc(input logic [15:0] a, input word_t e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("ack %h", a), 32'h1, {31'h0, got});
    chk($sformatf("read %h", a), e, q);
  endtask
  // Host set-up of the bridge chip before any local access, one read per host read
  task automatic bridge_init();
    bridge_cfg[0] = 32'h00000001;
    bridge_cfg[1] = 32'h40430343;
    bridge_cfg[2] = 32'h01200000;
    bridge_cfg[3] = 32'h0f000900;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    chk("io_oe_n", 32'hffffffff, io_oe_n[31:0]);
    rdc(`ADDR_BASE, `DESIGN_ID);
    rdc(`ADDR_OSC_CNT, 32'h0);
    rdc(`ADDR_OSC_DATA, 32'h0);
    bus(1'b1, `ADDR_BASE, 32'h0);
    rdc(`ADDR_BASE, `DESIGN_ID);
    rdc(16'h2100, 32'h0);
    bus(1'b0, 16'h1000, 32'h0);
    chk("ack outside", 32'h0, {31'h0, got});
  endtask
  task automatic t_io();
    logic [1:0] v, u;
    ext = 40'hc33cc33cc3;
    bus(1'b1, `ADDR_DIR_LO, 32'hffffe);
    bus(1'b1, `ADDR_DIR_HI, 32'h000ff);
    bus(1'b1, `ADDR_IO_LO, 32'ha5a5a);
    bus(1'b1, `ADDR_IO_HI, 32'h5a5a5);
    rdc(`ADDR_DIR_LO, 32'hffffe);
    chk("oe lo", 32'h1, {12'h0, io_oe_n[19:0]});
    chk("oe hi", 32'hfff00, {12'h0, io_oe_n[39:20]});
    chk("out lo", 32'h29696, {14'h0, io_out[19:2]});
    chk("out hi", 32'ha5, {24'h0, io_out[27:20]});
    rdc(`ADDR_IO_LO, 32'ha5a5a | {31'h0, ext[0]});
    rdc(`ADDR_IO_HI, 32'ha5 | {12'h0, ext[39:28], 8'h0});
    bus(1'b1, `ADDR_OSC_CNT, 32'h3);
    v = 2'b00;
    u = 2'b00;
    repeat (16) begin
      @(posedge clk) #1;
      v = v | {io_in[1], !io_in[1]};
      u = u | {io_in[0], !io_in[0]};
    end
    chk("clock on line", 32'h3, {30'h0, v});
    chk("clock kept off input line", 32'h2, {30'h0, u});
    chk("clock oe_n", 32'h1, {30'h0, io_oe_n[1:0]});
    bus(1'b1, `ADDR_OSC_CNT, 32'h0);
  endtask
  task automatic t_cnt();
    bus(1'b1, `ADDR_OSC_CNT, 32'h40000000);
    rdc(`ADDR_OSC_DATA, 32'h0);
    bus(1'b1, `ADDR_OSC_CNT, 32'h20000000);
    repeat (400) @(posedge clk);
    bus(1'b1, `ADDR_OSC_CNT, 32'h0);
    bus(1'b0, `ADDR_OSC_DATA, 32'h0);
    rng("count 0", 32'd46, 32'd56, q);
    bus(1'b1, `ADDR_OSC_CNT, 32'h01000000);
    bus(1'b0, `ADDR_OSC_DATA, 32'h0);
    rng("count 1", 32'd22, 32'd29, q);
    bus(1'b1, `ADDR_OSC_CNT, 32'h18000000);
    bus(1'b0, `ADDR_OSC_DATA, 32'h0);
    r = q;
    rng("count ref", 32'd396, 32'd410, r);
    bus(1'b1, `ADDR_OSC_CNT, 32'h1f000000);
    rdc(`ADDR_OSC_DATA, r);
  endtask
  task automatic t_ttl();
    ttl_low = 12'h002;
    bus(1'b1, `ADDR_TTL, 32'ha5a);
    repeat (3) @(posedge clk);
    chk("ttl_oe_n", 32'ha5a, {20'h0, ttl_oe_n});
    rdc(`ADDR_TTL, 32'ha58);
  endtask
  task automatic t_loop();
    fm_u.rx_full = 8'h08;
    for (int i = 0; i < 3; i++) fm_u.load(0, 32'h11110001 + i);
    fm_u.load(3, 32'h33330003);
    bus(1'b1, `ADDR_RXTX, 32'h09);
    repeat (30) @(posedge clk);
    rdc(`ADDR_FIFO_FLAG, 32'h000008f7);
    chk("ch0 count", 32'h3, word_t'(fm_u.rxq[0].size()));
    for (int i = 0; i < 3; i++) chk("ch0 word", 32'h11110001 + i, fm_u.rxq[0][i]);
    chk("ch3 held", 32'h0, word_t'(fm_u.rxq[3].size()));
    fm_u.rx_full = 8'h00;
    repeat (12) @(posedge clk);
    chk("ch3 word", 32'h33330003, fm_u.rxq[3][0]);
    bus(1'b1, `ADDR_RXTX, 32'h0);
    fm_u.load(0, 32'h5555aaaa);
    rdc(`ADDR_FIFO0, 32'h5555aaaa);
    bus(1'b1, 16'h2038, 32'h66660006);
    repeat (4) @(posedge clk);
    chk("ch6 word", 32'h66660006, fm_u.rxq[6][0]);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {lb_wr, lb_rd, lb_addr, lb_wdata} = '0;
    {pcnt, ext, ttl_low} = '0;
    {err_total, samples_checked, cyc} = '0;
    bridge_init();
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_io();
    t_cnt();
    t_ttl();
    t_loop();
    finish_test();
  end
endmodule
bind io_loopback_test_logic io_loop_properties chk_u (.clk(clk), .rst(rst),
  .lb_addr(lb_addr), .lb_wr(lb_wr), .lb_rd(lb_rd), .lb_ack(lb_ack), .lb_rdata(lb_rdata),
  .io_oe_n(io_oe_n), .ttl_out(ttl_out), .tx_empty(tx_empty), .rx_full(rx_full),
  .tx_rdata(tx_rdata), .tx_rd(tx_rd), .rx_wr(rx_wr), .rx_wdata(rx_wdata));
`default_nettype wire
